// file: mcs_pkg.sv
// package of constants for the memory control settings block
// Operation
// RULE1 - bit 30 enables transaction retry
// RULE2 - bit 29 flushes writes before reads
// RULE3 - bits 28:25 set bad device threshold
// RULE4 - threshold also counts scrub passes per decrement
// RULE5 - software programs nonzero threshold before enhanced scrub
// RULE6 - bit 24 pads latency, holds through reset
// RULE7 - read-only bit 23 reports address fuse
// RULE8 - bit 22 selects 36 or 38 bit decode
// RULE9 - bit 21 is scratch, no effect
// RULE10 - bit 20 clear stalls engine, set resets
// RULE11 - engine enable not kept by config save
// RULE12 - bit 16 stored, no mirroring function
// RULE13 - bit 8 selects scrub error detection mode
// RULE14 - bit 7 set restarts scrub at lowest address
// RULE15 - software clears scrub before interleave changes
// RULE16 - software never sets bit 6 with mirroring
// RULE17 - bit 5 enables northbound crc/ecc checking
// RULE18 - checking off ignores alerts, no logging
// RULE19 - scrub sets bit 4, write clears
// RULE20 - scrub disable mid pass halts, no flag
// RULE21 - activations per window scale by mode
// RULE22 - limit 0 unlimited, 168 full bandwidth
// RULE23 - counter restarts per window, holds off
`default_nettype none
package mcs_pkg;
  localparam logic [7:0]  ADDR_SETTINGS   = 8'h40;
  localparam logic [7:0]  ADDR_THROTTLE   = 8'h44;
  localparam logic [7:0]  ADDR_SCRUB_SIZE = 8'h48;
  localparam logic [7:0]  ADDR_STATUS     = 8'h4c;
  localparam int          BIT_RETRY       = 30;
  localparam int          BIT_FLUSH       = 29;
  localparam int          THR_HI          = 28;
  localparam int          THR_LO          = 25;
  localparam int          BIT_ALIGN       = 24;
  localparam int          BIT_FUSE        = 23;
  localparam int          BIT_WIDE        = 22;
  localparam int          BIT_INIT        = 21;
  localparam int          BIT_ENGINE      = 20;
  localparam int          BIT_MIRROR      = 16;
  localparam int          BIT_ALGO        = 8;
  localparam int          BIT_SCRUB       = 7;
  localparam int          BIT_DEMAND      = 6;
  localparam int          BIT_ERRCHK      = 5;
  localparam int          BIT_DONE        = 4;
  // writable bits of the settings word
  localparam logic [31:0] SETTINGS_WMASK  = 32'h7f7101e0;
  localparam logic [31:0] SETTINGS_RESET  = 32'h00000000;
  localparam logic [7:0]  ACT_LIMIT_MAX   = 8'ha8;
  localparam int          LIMIT_SHIFT_M0  = 16;
  localparam int          LIMIT_SHIFT_M1  = 4;
  localparam int          FRAME_CYCLES    = 1344;
  localparam int          WINDOW_M0       = 16384 * FRAME_CYCLES;
  localparam int          WINDOW_M1       = 4 * FRAME_CYCLES;
  localparam logic [31:0] SCRUB_SIZE_RST  = 32'h00000400;
  localparam logic [3:0]  BAD_DEVICE_COUNT_SAT      = 4'hf;
endpackage
`default_nettype wire

// file: mcs_settings.sv
// memory control settings register, scrub engine and activation throttle
//
// Our own choice: the Avalon-MM slave port.
`default_nettype none
module mcs_settings #(
  parameter int unsigned WINDOW_M0_CYC = mcs_pkg::WINDOW_M0, // long throttle window
  parameter int unsigned WINDOW_M1_CYC = mcs_pkg::WINDOW_M1  // short throttle window
) (
  input  wire logic        clk,             // 50 mhz core clock
  input  wire logic        rst,             // synchronous reset
  input  wire logic [7:0]  avs_address,     // byte address
  input  wire logic        avs_read,        // read request
  input  wire logic        avs_write,       // write request
  input  wire logic [31:0] avs_writedata,   // write data
  input  wire logic [3:0]  avs_byteenable,  // byte lanes
  output logic [31:0]      avs_readdata,    // read data
  output logic             avs_waitrequest, // stall
  output logic [1:0]       avs_response,    // 00 ok, 10 slave error
  input  wire logic        addr_width_fuse, // fuse pin, async
  input  wire logic        act_request,     // activation wanted
  output logic             act_grant,       // activation allowed
  input  wire logic        adj_symbol_err,  // adjacent symbol error pulse
  input  wire logic        nb_alert,        // northbound alert pulse
  input  wire logic        nb_error,        // northbound crc/ecc error pulse
  output logic             nb_error_log,    // logged northbound error
  output logic             nb_alert_seen,   // accepted alert
  output logic             retry_enable,    // retry on
  output logic             flush_writes,    // drain writes first
  output logic             frame_pad,       // pad round trip latency
  output logic             latency_hold,    // no latency growth on fast reset
  output logic             wide_decode,     // 38 bit decode
  output logic             engine_run,      // engine issues commands
  output logic             engine_reset,    // one-cycle engine reset
  output logic             scrub_enhanced,  // enhanced x8 detection
  output logic             demand_scrub,    // demand scrub on
  output logic             scrub_active,    // scrub pass running
  output logic [31:0]      scrub_addr,      // scrub address
  output logic             device_bad,      // device marked bad
  output logic [3:0]       bad_device_count // bad device counter
);
  logic [31:0] settings;
  logic [7:0]  act_limit;
  logic        window_mode;
  logic [31:0] scrub_size;
  logic        scrub_complete;
  logic        fuse_meta;
  logic        fuse_sync;
  logic        scrub_en_q;
  logic [3:0]  pass_count;
  logic [3:0]  adj_run;
  logic [31:0] win_count;
  logic [31:0] act_count;
  logic [31:0] act_allowed;
  logic        win_end;
  logic        scrub_step;
  logic        scrub_last;
  logic        sel_settings;
  logic        sel_throttle;
  logic        sel_size;
  logic        sel_status;
  logic        mapped;
  logic        rd_done;
  logic        wr_set;
  logic        wr_thr;
  logic        wr_size;
  logic [31:0] bemask;
  logic [3:0]  thresh;
  logic        engine_en_q;

  // address decode and lane mask
  assign sel_settings = avs_address == mcs_pkg::ADDR_SETTINGS;
  assign sel_throttle = avs_address == mcs_pkg::ADDR_THROTTLE;
  assign sel_size     = avs_address == mcs_pkg::ADDR_SCRUB_SIZE;
  assign sel_status   = avs_address == mcs_pkg::ADDR_STATUS;
  assign mapped       = sel_settings | sel_throttle | sel_size | sel_status;
  assign bemask       = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_set       = avs_write & ~avs_waitrequest & sel_settings;
  assign wr_thr       = avs_write & ~avs_waitrequest & sel_throttle;
  assign wr_size      = avs_write & ~avs_waitrequest & sel_size;
  assign thresh       = settings[mcs_pkg::THR_HI:mcs_pkg::THR_LO];

  // reads take one wait cycle, writes none
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_done <= 1'b0;
    else
      rd_done <= avs_read & ~rd_done;
  end
  assign avs_waitrequest = avs_read & ~rd_done;

  // read data and response registered in the wait cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'b00;
    end
    else if (avs_read & ~rd_done)
    begin
      avs_response <= mapped ? 2'b00 : 2'b10;
      // RULE7 fuse readback
      if (sel_settings)
        avs_readdata <= (settings & mcs_pkg::SETTINGS_WMASK)
                        | ({31'h0, fuse_sync} << mcs_pkg::BIT_FUSE)
                        | ({31'h0, scrub_complete} << mcs_pkg::BIT_DONE);
      else if (sel_throttle)
        avs_readdata <= {23'h0, window_mode, act_limit};
      else if (sel_size)
        avs_readdata <= scrub_size;
      else if (sel_status)
        avs_readdata <= {22'h0, act_count >= act_allowed, scrub_active,
                         device_bad, 1'b0, bad_device_count, 2'b00};
      else
        avs_readdata <= 32'h00000000;
    end
    else if (avs_write)
      avs_response <= mapped ? 2'b00 : 2'b10;
  end

  // fuse synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fuse_meta <= 1'b0;
      fuse_sync <= 1'b0;
    end
    else
    begin
      fuse_meta <= addr_width_fuse;
      fuse_sync <= fuse_meta;
    end
  end

  // settings register; engine enable always resets to zero
  always_ff @(posedge clk)
  begin
    if (rst)
      // RULE11 engine enable not saved
      settings <= mcs_pkg::SETTINGS_RESET;
    else if (wr_set)
      settings <= (settings & ~(bemask & mcs_pkg::SETTINGS_WMASK))
                  | (avs_writedata & bemask & mcs_pkg::SETTINGS_WMASK);
  end

  // throttle and scrub size registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      act_limit   <= 8'h00;
      window_mode <= 1'b0;
      scrub_size  <= mcs_pkg::SCRUB_SIZE_RST;
    end
    else
    begin
      // RULE22 limit clamped to 168
      if (wr_thr & avs_byteenable[0])
        act_limit <= (avs_writedata[7:0] > mcs_pkg::ACT_LIMIT_MAX)
                     ? mcs_pkg::ACT_LIMIT_MAX : avs_writedata[7:0];
      if (wr_thr & avs_byteenable[1])
        window_mode <= avs_writedata[8];
      if (wr_size)
        scrub_size <= (scrub_size & ~bemask) | (avs_writedata & bemask);
    end
  end

  // mode outputs straight from register bits
  // RULE1 retry enable
  assign retry_enable   = settings[mcs_pkg::BIT_RETRY];
  // RULE2 write flush
  assign flush_writes   = settings[mcs_pkg::BIT_FLUSH];
  // RULE6 frame alignment
  assign frame_pad      = settings[mcs_pkg::BIT_ALIGN];
  assign latency_hold   = settings[mcs_pkg::BIT_ALIGN];
  // RULE8 decoder mode
  assign wide_decode    = settings[mcs_pkg::BIT_WIDE];
  // RULE13 scrub algorithm
  assign scrub_enhanced = settings[mcs_pkg::BIT_ALGO];
  assign demand_scrub   = settings[mcs_pkg::BIT_DEMAND];
  // RULE9 RULE12 scratch and mirror bits only stored, drive nothing

  // engine enable rise gives a one-cycle synchronous reset
  always_ff @(posedge clk)
  begin
    if (rst)
      engine_en_q <= 1'b0;
    else
      engine_en_q <= settings[mcs_pkg::BIT_ENGINE];
  end
  // RULE10 stall and engine reset
  assign engine_run   = settings[mcs_pkg::BIT_ENGINE] & engine_en_q;
  assign engine_reset = settings[mcs_pkg::BIT_ENGINE] & ~engine_en_q;

  // northbound checking gate
  // RULE17 RULE18 checking gate
  assign nb_error_log  = settings[mcs_pkg::BIT_ERRCHK] & nb_error;
  assign nb_alert_seen = settings[mcs_pkg::BIT_ERRCHK] & nb_alert;

  // patrol scrub engine
  assign scrub_step = scrub_active & engine_run;
  assign scrub_last = scrub_addr >= scrub_size - 32'h1;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scrub_en_q   <= 1'b0;
      scrub_active <= 1'b0;
      scrub_addr   <= 32'h00000000;
    end
    else
    begin
      scrub_en_q <= settings[mcs_pkg::BIT_SCRUB];
      // RULE14 restart at lowest address
      if (settings[mcs_pkg::BIT_SCRUB] & ~scrub_en_q)
      begin
        scrub_active <= 1'b1;
        scrub_addr   <= 32'h00000000;
      end
      // RULE20 immediate halt
      else if (~settings[mcs_pkg::BIT_SCRUB])
        scrub_active <= 1'b0;
      else if (scrub_step)
      begin
        if (scrub_last)
          scrub_active <= 1'b0;
        else
          scrub_addr <= scrub_addr + 32'h1;
      end
    end
  end

  // done flag; hardware set wins over software clear
  always_ff @(posedge clk)
  begin
    if (rst)
      scrub_complete <= 1'b0;
    // RULE19 set on finished pass
    else if (scrub_step & scrub_last & settings[mcs_pkg::BIT_SCRUB])
      scrub_complete <= 1'b1;
    else if (wr_set & avs_byteenable[0] & avs_writedata[mcs_pkg::BIT_DONE])
      scrub_complete <= 1'b0;
  end

  // bad device tracking by threshold
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      adj_run          <= 4'h0;
      device_bad       <= 1'b0;
      bad_device_count <= 4'h0;
      pass_count       <= 4'h0;
    end
    else
    begin
      // RULE3 consecutive errors mark bad
      if (adj_symbol_err)
      begin
        if (adj_run + 4'h1 >= thresh && thresh != 4'h0)
        begin
          device_bad <= 1'b1;
          adj_run    <= 4'h0;
          if (bad_device_count != mcs_pkg::BAD_DEVICE_COUNT_SAT)
            bad_device_count <= bad_device_count + 4'h1;
        end
        else
          adj_run <= adj_run + 4'h1;
      end
      // RULE4 passes per decrement
      else if (scrub_step & scrub_last & settings[mcs_pkg::BIT_SCRUB])
      begin
        adj_run <= 4'h0;
        if (pass_count + 4'h1 >= thresh)
        begin
          pass_count <= 4'h0;
          if (bad_device_count != mcs_pkg::BAD_DEVICE_COUNT_SAT && bad_device_count != 4'h0)
            bad_device_count <= bad_device_count - 4'h1;
        end
        else
          pass_count <= pass_count + 4'h1;
      end
    end
  end

  // allowed activations per window
  // RULE21 mode scaling
  assign act_allowed = window_mode ? ({24'h0, act_limit} << mcs_pkg::LIMIT_SHIFT_M1)
                                   : ({24'h0, act_limit} << mcs_pkg::LIMIT_SHIFT_M0);
  assign win_end = window_mode ? (win_count >= WINDOW_M1_CYC - 1)
                               : (win_count >= WINDOW_M0_CYC - 1);
  // RULE22 zero limit means unlimited
  assign act_grant = act_request & engine_run
                     & ((act_limit == 8'h00) | (act_count < act_allowed));

  // window timer and activation counter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      win_count <= 32'h00000000;
      act_count <= 32'h00000000;
    end
    // RULE23 restart at window edge
    else if (win_end)
    begin
      win_count <= 32'h00000000;
      act_count <= 32'h00000000;
    end
    else
    begin
      win_count <= win_count + 32'h1;
      if (act_grant)
        act_count <= act_count + 32'h1;
    end
  end
endmodule
`default_nettype wire

// file: mcs_settings_props.sv
// assertion checker for the memory control settings block
`default_nettype none
module mcs_settings_props (
  input wire logic        clk,             // clock
  input wire logic        rst,             // reset
  input wire logic [7:0]  avs_address,     // address
  input wire logic        avs_write,       // write
  input wire logic [31:0] avs_writedata,   // data
  input wire logic [3:0]  avs_byteenable,  // lanes
  input wire logic        avs_waitrequest, // stall
  input wire logic        nb_error,        // error in
  input wire logic        nb_alert,        // alert in
  input wire logic        nb_error_log,    // logged error
  input wire logic        nb_alert_seen,   // seen alert
  input wire logic        retry_enable,    // retry
  input wire logic        wide_decode,     // decode width
  input wire logic        engine_run,      // engine on
  input wire logic        engine_reset,    // engine reset
  input wire logic        scrub_enhanced,  // enhanced scrub
  input wire logic        scrub_active,    // scrub running
  input wire logic [31:0] scrub_addr       // scrub address
);
  logic wr_set;
  logic errchk_q;
  // settings write taken at this edge
  assign wr_set = avs_write && !avs_waitrequest && avs_address == mcs_pkg::ADDR_SETTINGS;
  // shadow of the northbound check enable, taken from settings writes
  always_ff @(posedge clk)
  begin
    if (rst)
      errchk_q <= 1'b0;
    else if (wr_set && avs_byteenable[0])
      errchk_q <= avs_writedata[5];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_retry; wr_set && avs_byteenable[3] |=> retry_enable == $past(avs_writedata[30]);
  endproperty
  property p_wide; wr_set && avs_byteenable[2] |=> wide_decode == $past(avs_writedata[22]);
  endproperty
  property p_enh; wr_set && avs_byteenable[1] |=> scrub_enhanced == $past(avs_writedata[8]);
  endproperty
  property p_eng_pulse; engine_reset |-> !engine_run ##1 !engine_reset; endproperty
  property p_eng_stop; wr_set && avs_byteenable[2] && !avs_writedata[20] |=> !engine_run [*2];
  endproperty
  property p_scrub_start; $rose(scrub_active) |-> scrub_addr == 32'h0; endproperty
  property p_scrub_halt; wr_set && avs_byteenable[0] && !avs_writedata[7] |-> ##2 !scrub_active;
  endproperty
  property p_nb_log; nb_error_log == (nb_error && errchk_q); endproperty
  property p_nb_alert; nb_alert_seen == (nb_alert && errchk_q); endproperty
  a_retry: assert property (p_retry) else $error("retry level wrong");
  a_wide: assert property (p_wide) else $error("decode width wrong");
  a_enh: assert property (p_enh) else $error("scrub mode wrong");
  a_eng_pulse: assert property (p_eng_pulse) else $error("engine reset bad");
  a_eng_stop: assert property (p_eng_stop) else $error("engine not stopped");
  a_scrub_start: assert property (p_scrub_start) else $error("scrub start addr");
  a_scrub_halt: assert property (p_scrub_halt) else $error("scrub not halted");
  a_nb_log: assert property (p_nb_log) else $error("error log bad");
  a_nb_alert: assert property (p_nb_alert) else $error("alert seen bad");
  // main scenarios reached
  c_scrub: cover property ($rose(scrub_active));
  c_eng: cover property (engine_reset);
  c_log: cover property (nb_error_log);
endmodule
bind mcs_settings mcs_settings_props chk_u (.clk, .rst, .avs_address, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .nb_error, .nb_alert, .nb_error_log,
  .nb_alert_seen, .retry_enable, .wide_decode, .engine_run, .engine_reset,
  .scrub_enhanced, .scrub_active, .scrub_addr);
`default_nettype wire

// file: mcs_dimm_model.sv
// far side model: activation requests and northbound event pulses
`default_nettype none
module mcs_dimm_model (
  input wire logic       clk,            // clock
  input wire logic       rst,            // reset
  input wire logic       req_on,         // keep requesting
  input wire logic [2:0] fire,           // adj, alert, error wanted
  output logic           act_request,    // activation wanted
  output logic           adj_symbol_err, // pulse
  output logic           nb_alert,       // pulse
  output logic           nb_error        // pulse
);
  // one-cycle pulses, every other cycle while fire is held
  always_ff @(posedge clk)
  begin
    if (rst)
      {act_request, adj_symbol_err, nb_alert, nb_error} <= 4'h0;
    else
    begin
      act_request <= req_on;
      {adj_symbol_err, nb_alert, nb_error} <= fire & ~{adj_symbol_err, nb_alert, nb_error};
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
// self-checking testbench for the memory control settings block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, avs_read, avs_write, fuse, req_on, avs_waitrequest, md;
  logic        act_request, act_grant, adj_symbol_err, nb_alert, nb_error;
  logic        nb_error_log, nb_alert_seen, device_bad;
  logic [7:0]  avs_address, lim;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [2:0]  fire;
  logic [1:0]  rsp;
  logic [31:0] exp_q[$];
  integer      seed;
  int          fails, tests_run, grants, logs, alerts, g0, w, per;
  mcs_settings #(.WINDOW_M0_CYC(200), .WINDOW_M1_CYC(40)) dut_u (.clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .avs_response(rsp), .addr_width_fuse(fuse), .act_request, .act_grant,
    .adj_symbol_err, .nb_alert, .nb_error, .nb_error_log, .nb_alert_seen, .retry_enable(),
    .flush_writes(), .frame_pad(), .latency_hold(), .wide_decode(), .engine_run(),
    .engine_reset(), .scrub_enhanced(), .demand_scrub(), .scrub_active(), .scrub_addr(),
    .device_bad, .bad_device_count());
  mcs_dimm_model far_u (.clk, .rst, .req_on, .fire, .act_request, .adj_symbol_err,
    .nb_alert, .nb_error);
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("CHECK FAILED %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [2:0] f, input int n);
    fire <= f;
    repeat (n) @(posedge clk);
    fire <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic complete_run();
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // clock of 20 ns
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // read data checked against the oldest note
  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check_word(avs_readdata, exp_q.pop_front());
  end
  // event counters
  always @(posedge clk)
  begin
    if (act_request === 1'b1 && act_grant === 1'b1)
      grants++;
    if (nb_error_log === 1'b1)
      logs++;
    if (nb_alert_seen === 1'b1)
      alerts++;
  end
  // watchdog
  initial
  begin
    #1000000;
    fails++;
    complete_run();
  end
  // main sequence
  initial
  begin
    seed = 32'h0ebc;
    {rst, avs_read, avs_write, fuse, req_on, fire} = 8'h80;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus_read(mcs_pkg::ADDR_SETTINGS, mcs_pkg::SETTINGS_RESET);
    check_word({30'h0, rsp}, 32'h0);
    bus_read(8'h50, 32'h0);
    check_word({30'h0, rsp}, 32'h2);
    fuse <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed) & ~32'h00000090;
      if (r[16])
        r[6] = 1'b0;
      if (r[28:25] == 4'h0)
        r[25] = 1'b1;
      bus_write(mcs_pkg::ADDR_SETTINGS, r);
      bus_read(mcs_pkg::ADDR_SETTINGS, (r & mcs_pkg::SETTINGS_WMASK) | 32'h00800000);
    end
    bus_write(mcs_pkg::ADDR_SCRUB_SIZE, 32'h8);
    bus_read(mcs_pkg::ADDR_SCRUB_SIZE, 32'h8);
    bus_write(mcs_pkg::ADDR_SETTINGS, 32'h00100080);
    repeat (30) @(posedge clk);
    bus_read(mcs_pkg::ADDR_SETTINGS, 32'h00900090);
    bus_write(mcs_pkg::ADDR_SETTINGS, 32'h00100010);
    bus_read(mcs_pkg::ADDR_SETTINGS, 32'h00900000);
    bus_write(mcs_pkg::ADDR_SCRUB_SIZE, 32'h400);
    bus_write(mcs_pkg::ADDR_SETTINGS, 32'h00100080);
    repeat (5) @(posedge clk);
    // scrub off before any range change
    bus_write(mcs_pkg::ADDR_SETTINGS, 32'h00100000);
    bus_read(mcs_pkg::ADDR_SETTINGS, 32'h00900000);
    for (int e = 1; e >= 0; e--)
    begin
      bus_write(mcs_pkg::ADDR_SETTINGS, e ? 32'h20 : 32'h0);
      g0 = logs;
      w = alerts;
      pulse(3'b011, 1);
      check_count(logs - g0, e, e);
      check_count(alerts - w, e, e);
    end
    // threshold of three
    // engine kept on so the throttle scenarios can grant
    bus_write(mcs_pkg::ADDR_SETTINGS, 32'h06100000);
    pulse(3'b100, 4);
    check_word({31'h0, device_bad}, 32'h0);
    pulse(3'b100, 6);
    check_word({31'h0, device_bad}, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      lim = (k == 4) ? 8'd200 : (k == 5) ? 8'd1 : k[7:0];
      md = (k != 5);
      w = md ? 40 : 200;
      per = ((lim > 8'ha8) ? 168 : int'(lim)) << (md ? 4 : 16);
      bus_write(mcs_pkg::ADDR_THROTTLE, {23'h0, md, lim});
      bus_read(mcs_pkg::ADDR_THROTTLE, {23'h0, md, (lim > 8'ha8) ? 8'ha8 : lim});
      g0 = grants;
      req_on <= 1'b1;
      repeat (400) @(posedge clk);
      req_on <= 1'b0;
      repeat (3) @(posedge clk);
      if (lim == 8'h0 || per >= w)
        check_count(grants - g0, 400, 400);
      else
        check_count(grants - g0, (400 / w - 1) * per, (400 / w + 1) * per);
    end
    complete_run();
  end
endmodule
`default_nettype wire
